// ### include/energy_pulse_pkg.sv
// package with constants and carriers for the energy pulse output stage
// Contract
// - after reset select normal format; pulse_a gives active-low power-proportional pulses
// - normal: positive pulses a only, b high; negative pulses both together
// - full-scale power gives average pulse_a rate equal to main_pulse_rate; code rate falls as main_pulse_rate rises (one quantum per pulse)
// - normal pulses never faster than divided clock over 16
// - normal pulse width whole clock cycles, about 1/(8*main_pulse_rate); code uses a fixed WORD_DIV/DUR_DIV clocks
// - normal width bounded between 16/8 and 1024/8 clock-derived limits
// - pulse_width_count ignored in normal format
// - alternating format when alternating and counter selected, motor not
// - alternating pulses alternate a/b, each pulse_width_count word periods long
// - alternating format shows no energy direction
// - counter format when counter selected only
// - counter format: positive pulses on a, negative on b
// - counter width from pulse_width_count, default 512 samples
// - motor-drive format when motor selected only
// - motor-drive toggles outputs alternately on each energy quantum
// - motor-drive positive changes a first, negative changes b first
// - pulse_width_count ignored in motor-drive format
// - calib_pulse_out rate proportional to power, scaled by calib_pulse_rate
// - calib pulses for both signs, no direction indication
// - calib width is calib_width_count word periods, default 0
// - creep enables suppress pulses while accumulated magnitude below creep level
// - counter and motor formats accumulate signed power, pulse per quantum
// - normal and alternating formats use plus/minus 8x quantum buffer first
// - calib output may reach 512 kHz depending on calib_pulse_rate; code fires at most once per word tick (WORD_DIV clocks)
package energy_pulse_pkg;
   localparam int          POWER_W       = 24;
   localparam int          ACC_W         = 40;
   localparam int          RATE_W        = 24;
   localparam int          WIDTH_W       = 16;
   localparam int          WORD_DIV      = 1024;
   localparam int          MIN_PERIOD    = 16;
   localparam int          BUF_MULT      = 8;
   localparam int          DUR_DIV       = 8;
   localparam logic [15:0] PW_RESET      = 16'h0200;
   localparam logic [15:0] CALIB_W_RESET = 16'h0000;
   localparam real         CLK_MHZ       = 125.0;
   localparam real         CALIB_MAX_KHZ = 512.0;
   localparam int          CALIB_MIN_CYC = int'(CLK_MHZ * 1000.0 / CALIB_MAX_KHZ);

   typedef enum logic [3:0] {
      FMT_NORMAL  = 4'b0001,
      FMT_ALT     = 4'b0010,
      FMT_COUNTER = 4'b0100,
      FMT_MOTOR   = 4'b1000
   } format_t;

   typedef struct packed {
      logic alternating_select;
      logic counter_select;
      logic motor_drive_select;
      logic main_creep_enable;
      logic calib_creep_enable;
   } config_t;
endpackage : energy_pulse_pkg

// ### core/energy_pulse_output.sv
// energy to pulse converter for the main and calibration outputs
`timescale 1ns/10ps
module energy_pulse_output #(
   parameter int WORD_DIV = energy_pulse_pkg::WORD_DIV
) (
   input  wire logic                                    clk_sys,           // divided master clock
   input  wire logic                                    rst_n,             // async reset, active low
   input  wire logic signed [energy_pulse_pkg::POWER_W-1:0] power_sample,  // instantaneous active power
   input  wire energy_pulse_pkg::config_t               cfg,               // format and creep selects
   input  wire logic [energy_pulse_pkg::RATE_W-1:0]     main_pulse_rate,   // main quantum step
   input  wire logic [energy_pulse_pkg::RATE_W-1:0]     calib_pulse_rate,  // calib quantum step
   input  wire logic [energy_pulse_pkg::WIDTH_W-1:0]    pulse_width_count, // width in word periods
   input  wire logic [energy_pulse_pkg::WIDTH_W-1:0]    calib_width_count, // calib width in word periods
   input  wire logic [energy_pulse_pkg::ACC_W-2:0]      creep_level,       // anti-creep magnitude
   input  wire logic                                    pw_load,           // load width settings
   output logic                                         energy_pulse_a,    // main output a, active low
   output logic                                         energy_pulse_b,    // main output b, active low
   output logic                                         calib_pulse_out,   // calibration output, active low
   output logic                                         word_tick          // word-rate strobe
);
   localparam int ACC_W = energy_pulse_pkg::ACC_W;
   localparam int WW    = energy_pulse_pkg::WIDTH_W;
   localparam int QSH   = 16;  // quantum is rate shifted up, fixed scaling

   energy_pulse_pkg::format_t fmt_reg, fmt_next;
   logic [9:0]               div_reg;
   logic signed [ACC_W-1:0]  acc_main_reg, acc_cal_reg;
   logic [WW-1:0]            pw_reg, cw_reg;
   logic [WW-1:0]            wcnt_reg, ccnt_reg;
   logic [7:0]               ncnt_reg;
   logic [7:0]               gap_reg;
   logic                     alt_side_reg, step_reg;
   logic signed [ACC_W-1:0]  q_main, q_cal, mbuf, sum_main, sum_cal;
   logic                     fire_pos, fire_neg, cal_fire;

   // magnitude compare used for both creep gates
   function automatic logic below_creep(input logic signed [ACC_W-1:0] a, input logic [ACC_W-2:0] lvl);
      logic [ACC_W-1:0] m;
      m = a[ACC_W-1] ? ACC_W'(-a) : a;
      return m < {1'b0, lvl};
   endfunction : below_creep

   // format decode from the three selects
   always_comb begin
      fmt_next = energy_pulse_pkg::FMT_NORMAL;
      if (cfg.alternating_select && cfg.counter_select && !cfg.motor_drive_select)
         fmt_next = energy_pulse_pkg::FMT_ALT;
      else if (!cfg.alternating_select && cfg.counter_select && !cfg.motor_drive_select)
         fmt_next = energy_pulse_pkg::FMT_COUNTER;
      else if (!cfg.alternating_select && !cfg.counter_select && cfg.motor_drive_select)
         fmt_next = energy_pulse_pkg::FMT_MOTOR;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) fmt_reg <= energy_pulse_pkg::FMT_NORMAL;
      else        fmt_reg <= fmt_next;
   end

   // word-rate divider
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_reg   <= 10'h000;
         word_tick <= 1'b0;
      end else begin
         word_tick <= (div_reg == 10'(WORD_DIV - 1));
         div_reg   <= (div_reg == 10'(WORD_DIV - 1)) ? 10'h000 : div_reg + 10'h001;
      end
   end

   // width settings
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pw_reg <= energy_pulse_pkg::PW_RESET;
         cw_reg <= energy_pulse_pkg::CALIB_W_RESET;
      end else if (pw_load) begin
         pw_reg <= pulse_width_count;
         cw_reg <= calib_width_count;
      end
   end

   // accumulation and firing decisions
   always_comb begin
      q_main   = ACC_W'({main_pulse_rate, {QSH{1'b0}}});
      q_cal    = ACC_W'({calib_pulse_rate, {QSH{1'b0}}});
      mbuf     = (fmt_reg == energy_pulse_pkg::FMT_NORMAL || fmt_reg == energy_pulse_pkg::FMT_ALT)
                 ? ACC_W'(q_main * energy_pulse_pkg::BUF_MULT) : q_main;
      sum_main = acc_main_reg + ACC_W'(power_sample);
      sum_cal  = acc_cal_reg + ACC_W'(power_sample);
      fire_pos = word_tick && (q_main != '0) && (sum_main >= mbuf)
                 && !(cfg.main_creep_enable && below_creep(sum_main, creep_level));
      fire_neg = word_tick && (q_main != '0) && (sum_main <= -mbuf)
                 && !(cfg.main_creep_enable && below_creep(sum_main, creep_level));
      cal_fire = word_tick && (q_cal != '0) && ((sum_cal >= q_cal) || (sum_cal <= -q_cal))
                 && !(cfg.calib_creep_enable && below_creep(sum_cal, creep_level));
   end

   // signed accumulators, one quantum removed per fire decision, pulse started or not
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_main_reg <= '0;
         acc_cal_reg  <= '0;
      end else if (word_tick) begin
         acc_main_reg <= fire_pos ? sum_main - q_main : fire_neg ? sum_main + q_main : sum_main;
         acc_cal_reg  <= (cal_fire && sum_cal >= 0) ? sum_cal - q_cal
                       : cal_fire ? sum_cal + q_cal : sum_cal;
      end
   end

   // main outputs per format
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         energy_pulse_a <= 1'b1;
         energy_pulse_b <= 1'b1;
         ncnt_reg       <= 8'h00;
         wcnt_reg       <= '0;
         alt_side_reg   <= 1'b0;
         step_reg       <= 1'b0;
      end else begin
         unique case (fmt_reg)
            energy_pulse_pkg::FMT_NORMAL: begin
               // fixed width of WORD_DIV/DUR_DIV clocks, spacing at least MIN_PERIOD
               if (ncnt_reg != 8'h00) begin
                  ncnt_reg <= ncnt_reg - 8'h01;
                  if (ncnt_reg == 8'h01) begin
                     energy_pulse_a <= 1'b1;
                     energy_pulse_b <= 1'b1;
                  end
               end else if (fire_pos || fire_neg) begin
                  ncnt_reg       <= 8'(WORD_DIV / energy_pulse_pkg::DUR_DIV);
                  energy_pulse_a <= 1'b0;
                  energy_pulse_b <= !fire_neg;
               end
            end
            energy_pulse_pkg::FMT_ALT, energy_pulse_pkg::FMT_COUNTER: begin
               if (wcnt_reg != '0) begin
                  // release on the tick that closes the last word period, so width is exact
                  if (word_tick) begin
                     wcnt_reg <= wcnt_reg - 1'b1;
                     if (wcnt_reg == WW'(1)) begin
                        energy_pulse_a <= 1'b1;
                        energy_pulse_b <= 1'b1;
                     end
                  end
               end else if ((fire_pos || fire_neg) && pw_reg != '0) begin
                  wcnt_reg <= pw_reg;
                  if (fmt_reg == energy_pulse_pkg::FMT_ALT) begin
                     energy_pulse_a <= alt_side_reg;
                     energy_pulse_b <= !alt_side_reg;
                     alt_side_reg   <= !alt_side_reg;
                  end else begin
                     energy_pulse_a <= !fire_pos;
                     energy_pulse_b <= !fire_neg;
                  end
               end else begin
                  energy_pulse_a <= 1'b1;
                  energy_pulse_b <= 1'b1;
               end
            end
            energy_pulse_pkg::FMT_MOTOR: begin
               // two-phase sequence; direction sets which output changes first
               if (fire_pos || fire_neg) begin
                  if (step_reg == fire_neg) energy_pulse_a <= !energy_pulse_a;
                  else                      energy_pulse_b <= !energy_pulse_b;
                  step_reg <= !step_reg;
               end
            end
         endcase
      end
   end

   // calibration output, width in word periods with a minimum gap for rate cap
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         calib_pulse_out <= 1'b1;
         ccnt_reg        <= '0;
         gap_reg         <= 8'h00;
      end else begin
         if (gap_reg != 8'h00) gap_reg <= gap_reg - 8'h01;
         if (ccnt_reg != '0) begin
            if (word_tick) ccnt_reg <= ccnt_reg - 1'b1;
            if (word_tick && ccnt_reg == WW'(1)) calib_pulse_out <= 1'b1;
         end else if (cal_fire && gap_reg == 8'h00) begin
            gap_reg         <= 8'(energy_pulse_pkg::CALIB_MIN_CYC);
            calib_pulse_out <= (cw_reg == '0);
            ccnt_reg        <= cw_reg;
         end
      end
   end

   // normal pulse stays low at least eight clocks
   normal_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_NORMAL && $fell(energy_pulse_a)) |-> !energy_pulse_a [*8])
      else $error("normal pulse too short");
   // positive normal pulse keeps b high
   normal_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_NORMAL && $past(fire_pos) && $fell(energy_pulse_a)) |-> energy_pulse_b)
      else $error("direction shown on positive energy");
   // normal pulses spaced at least eight clocks
   normal_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_NORMAL && $rose(energy_pulse_a)) |-> energy_pulse_a [*8])
      else $error("normal pulse rate too high");
   // counter format routes negative to b only
   counter_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_COUNTER && wcnt_reg == '0 && fire_neg && pw_reg != '0)
      |=> (energy_pulse_a && !energy_pulse_b))
      else $error("counter routing wrong");
   // alternating never drives both low
   alt_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fmt_reg == energy_pulse_pkg::FMT_ALT |-> (energy_pulse_a || energy_pulse_b))
      else $error("alternating pulses overlap");
   // motor toggles one output per quantum
   motor_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_MOTOR && $past(fmt_reg) == energy_pulse_pkg::FMT_MOTOR
       && (fire_pos || fire_neg)) |=> ($changed(energy_pulse_a) != $changed(energy_pulse_b)))
      else $error("motor step wrong");
   // accumulator only moves on word ticks
   word_accum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !$past(word_tick) |-> $stable(acc_main_reg))
      else $error("accumulator moved off tick");
   // motor format follows select decode
   format_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cfg.motor_drive_select && !cfg.counter_select && !cfg.alternating_select)
      |=> fmt_reg == energy_pulse_pkg::FMT_MOTOR)
      else $error("motor format not selected");
   // negative normal pulse drives both outputs together
   normal_neg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_NORMAL && $past(fire_neg) && $fell(energy_pulse_a))
      |-> !energy_pulse_b)
      else $error("negative normal pulse missing on b");
   // in normal format b never falls without a
   normal_b_alone_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_NORMAL && $past(fmt_reg) == energy_pulse_pkg::FMT_NORMAL
       && $fell(energy_pulse_b))
      |-> !energy_pulse_a)
      else $error("b pulsed alone in normal format");
   // normal width counter never above the fixed width
   normal_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fmt_reg == energy_pulse_pkg::FMT_NORMAL
      |-> ncnt_reg <= 8'(WORD_DIV / energy_pulse_pkg::DUR_DIV))
      else $error("normal width out of bounds");
   // counter format routes positive to a only
   counter_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_COUNTER && wcnt_reg == '0 && fire_pos && pw_reg != '0)
      |=> (!energy_pulse_a && energy_pulse_b))
      else $error("counter positive routing wrong");
   // an alternating pulse starts on exactly one output
   alt_one_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_ALT && wcnt_reg == '0 && (fire_pos || fire_neg) && pw_reg != '0)
      |=> (energy_pulse_a != energy_pulse_b))
      else $error("alternating pulse not on one output");
   // the next alternating pulse uses the other output
   alt_swap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_ALT && wcnt_reg == '0 && (fire_pos || fire_neg) && pw_reg != '0)
      |=> alt_side_reg != $past(alt_side_reg))
      else $error("alternating side did not swap");
   // a running width pulse holds both outputs
   pulse_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((fmt_reg == energy_pulse_pkg::FMT_ALT || fmt_reg == energy_pulse_pkg::FMT_COUNTER)
       && wcnt_reg != '0 && !(word_tick && wcnt_reg == WW'(1)))
      |=> ($stable(energy_pulse_a) && $stable(energy_pulse_b)))
      else $error("width pulse changed early");
   // width pulse ends on the closing word tick
   pulse_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((fmt_reg == energy_pulse_pkg::FMT_ALT || fmt_reg == energy_pulse_pkg::FMT_COUNTER)
       && word_tick && wcnt_reg == WW'(1))
      |=> (energy_pulse_a && energy_pulse_b))
      else $error("width pulse did not end");
   // motor outputs hold between quanta
   motor_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_MOTOR && !fire_pos && !fire_neg)
      |=> ($stable(energy_pulse_a) && $stable(energy_pulse_b)))
      else $error("motor output moved without quantum");
   // positive motor sequence changes a first
   motor_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fmt_reg == energy_pulse_pkg::FMT_MOTOR && fire_pos && !step_reg)
      |=> $changed(energy_pulse_a))
      else $error("motor positive order wrong");
   // zero calibration width gives no low level
   calib_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cw_reg == '0 && ccnt_reg == '0)
      |=> calib_pulse_out)
      else $error("calib low with zero width");
   // calibration pulse ends on the closing word tick
   calib_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (word_tick && ccnt_reg == WW'(1))
      |=> calib_pulse_out)
      else $error("calib pulse did not end");
   // a calibration fire with gap and width idle starts the rate gap
   calib_space_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cal_fire && gap_reg == 8'h00 && ccnt_reg == '0)
      |=> gap_reg == 8'(energy_pulse_pkg::CALIB_MIN_CYC))
      else $error("calib rate gap not started");
   // word tick lasts a single cycle
   tick_single_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      word_tick
      |=> !word_tick)
      else $error("word tick too long");
   // without a fire the sample is kept whole
   acc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (word_tick && !fire_pos && !fire_neg)
      |=> acc_main_reg == $past(sum_main))
      else $error("accumulator lost energy");
   // alternating decode
   alt_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cfg.alternating_select && cfg.counter_select && !cfg.motor_drive_select)
      |=> fmt_reg == energy_pulse_pkg::FMT_ALT)
      else $error("alternating format not selected");
   // counter decode
   counter_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!cfg.alternating_select && cfg.counter_select && !cfg.motor_drive_select)
      |=> fmt_reg == energy_pulse_pkg::FMT_COUNTER)
      else $error("counter format not selected");
endmodule : energy_pulse_output

// ### bench/pulse_observer.sv
// counter and test-meter model that times low pulses on the three outputs
`timescale 1ns/10ps
module pulse_observer (
   input  wire logic       clk_sys, // sampling clock
   input  wire logic       rst_n,   // async reset, active low
   input  wire logic [2:0] line,    // levels of a, b and calib
   output logic [2:0][15:0] width,  // last completed low width
   output logic [2:0][7:0]  falls   // falling edges seen
);
   logic [2:0][15:0] run_reg;
   logic [2:0]       line_reg;
   // count low cycles, latch them when the line returns high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= '0;
         width <= '0;
         falls <= '0;
         line_reg <= 3'h7;
      end else begin
         line_reg <= line;
         for (int k = 0; k < 3; k++) begin
            run_reg[k] <= line[k] ? 16'h0000 : run_reg[k] + 16'h0001;
            if (line[k] && !line_reg[k]) width[k] <= run_reg[k];
            if (!line[k] && line_reg[k]) falls[k] <= falls[k] + 8'h01;
         end
      end
   end
endmodule : pulse_observer

// ### bench/energy_pulse_output_bench.sv
// self-checking bench for the energy pulse stage, run with a short word period
`timescale 1ns/10ps
module energy_pulse_output_bench;
   localparam int WD = 64;
   typedef struct {
      logic [4:0]  cfg;
      logic        neg;
      logic [1:0]  exp;
      logic        one;
      logic [15:0] wid;
   } row_t;
   logic                    clk_sys = 1'b0;
   logic                    rst_n = 1'b0;
   logic signed [23:0]      power_sample = 24'sh000000;
   energy_pulse_pkg::config_t cfg = '0;
   logic [23:0]             main_pulse_rate = 24'h000001;
   logic [23:0]             calib_pulse_rate = 24'h000001;
   logic [15:0]             pulse_width_count = 16'h0002;
   logic [15:0]             calib_width_count = 16'h0001;
   logic [38:0]             creep_level = '0;
   logic                    pw_load = 1'b0;
   logic                    energy_pulse_a, energy_pulse_b, calib_pulse_out, word_tick;
   logic [2:0][15:0]        width;
   logic [2:0][7:0]         falls;
   logic [1:0]              first;
   row_t                    rows [8];
   int                      n_mismatch = 0;
   int                      n_checks = 0;

   // free-running system clock
   always #4 clk_sys = ~clk_sys;

   energy_pulse_output #(.WORD_DIV(WD)) i_energy_pulse_output (.clk_sys(clk_sys), .rst_n(rst_n),
      .power_sample(power_sample), .cfg(cfg), .main_pulse_rate(main_pulse_rate),
      .calib_pulse_rate(calib_pulse_rate), .pulse_width_count(pulse_width_count),
      .calib_width_count(calib_width_count), .creep_level(creep_level), .pw_load(pw_load),
      .energy_pulse_a(energy_pulse_a), .energy_pulse_b(energy_pulse_b),
      .calib_pulse_out(calib_pulse_out), .word_tick(word_tick));

   pulse_observer i_pulse_observer (.clk_sys(clk_sys), .rst_n(rst_n),
      .line({energy_pulse_a, energy_pulse_b, calib_pulse_out}), .width(width), .falls(falls));

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // bounded wait until the main outputs are both idle or one is low
   task wait_main(input logic idle);
      for (int i = 0; i < 40000; i++) begin
         @(negedge clk_sys);
         if ((energy_pulse_a && energy_pulse_b) == idle) return;
      end
      n_mismatch++;
      $display("wait on main outputs timed out at %0t", $time);
      end_of_test();
   endtask : wait_main

   // reset for six cycles with a format and power sign, optionally loading widths
   task do_reset(input logic [4:0] c, input logic neg, input logic load);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      cfg <= energy_pulse_pkg::config_t'(c);
      power_sample <= neg ? -24'sh100000 : 24'sh100000;
      pw_load <= load;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      pw_load <= 1'b0;
   endtask : do_reset

   // format rows: select bits, sign, first {a,b}, one-hot only, low width
   initial begin
      rows[0] = '{5'h00, 1'b0, 2'b01, 1'b0, 16'h0008};
      rows[1] = '{5'h00, 1'b1, 2'b00, 1'b0, 16'h0008};
      rows[2] = '{5'h1c, 1'b1, 2'b00, 1'b0, 16'h0008};
      rows[3] = '{5'h08, 1'b0, 2'b01, 1'b0, 16'h0080};
      rows[4] = '{5'h08, 1'b1, 2'b10, 1'b0, 16'h0080};
      rows[5] = '{5'h04, 1'b0, 2'b01, 1'b0, 16'h0000};
      rows[6] = '{5'h04, 1'b1, 2'b10, 1'b0, 16'h0000};
      rows[7] = '{5'h18, 1'b1, 2'b00, 1'b1, 16'h0080};
      do_reset(5'h00, 1'b0, 1'b1);
      @(negedge clk_sys);
      chk({12'h000, energy_pulse_a, energy_pulse_b, calib_pulse_out, word_tick}, 16'h000e);
      for (int r = 0; r < 8; r++) begin
         do_reset(rows[r].cfg, rows[r].neg, 1'b1);
         wait_main(1'b0);
         first = {energy_pulse_a, energy_pulse_b};
         if (rows[r].one) chk({15'h0000, ^first}, 16'h0001);
         else chk({14'h0000, first}, {14'h0000, rows[r].exp});
         if (rows[r].wid != 16'h0000) begin
            wait_main(1'b1);
            @(negedge clk_sys);
            chk(first[1] ? width[1] : width[2], rows[r].wid);
         end
      end
      // alternating outputs swap on the next pulse; calib pulsed for negative power
      wait_main(1'b0);
      chk({14'h0000, energy_pulse_a, energy_pulse_b}, {14'h0000, ~first});
      chk(width[0], 16'h0040);
      // creep suppression on the main path (calib width is zero after this reset), then default counter width
      creep_level <= '1;
      do_reset(5'h0b, 1'b0, 1'b0);
      repeat (2000) @(negedge clk_sys);
      chk({8'h00, falls[2]}, 16'h0000);
      chk({8'h00, falls[0]}, 16'h0000);
      @(posedge clk_sys);
      creep_level <= '0;
      wait_main(1'b0);
      wait_main(1'b1);
      @(negedge clk_sys);
      chk(width[2], 16'h8000);
      end_of_test();
   end
endmodule : energy_pulse_output_bench
